// *** core/p1ovr_pump_clk.sv ***
// Charge pump clock divider for the regulated port outputs
`timescale 1ns/1ps
module p1ovr_pump_clk
	import p1ovr_pkg::*;
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// Control
	p1ovr_pump_if.pump pif
);
	logic [3:0] div_req;
	logic [3:0] count;
	logic [3:0] next_count;
	logic       next_pump;
	logic       pump_q;
	logic [3:0] gap;
	logic [3:0] next_gap;

	// Requested ratio: the minimum, or twice the minimum for DIV2, so the pump stays under its ceiling
	always_comb begin
		if (pif.clk_sel == P1OVR_CLKSEL_DIV2) begin
			div_req = 4'h2 * P1OVR_PUMP_MIN_DIV_W;
		end else begin
			div_req = P1OVR_PUMP_MIN_DIV_W;
		end
		if (count + 4'h1 >= div_req) begin
			next_count = 4'h0;
			next_pump  = 1'b1;
		end else begin
			next_count = count + 4'h1;
			next_pump  = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			count  <= 4'h0;
			pump_q <= 1'b0;
		end else begin
			count  <= next_count;
			pump_q <= next_pump;
		end
	end

	// Cycles since the last pulse, saturating; lets the rate check see the real spacing
	always_comb begin
		if (pump_q) begin
			next_gap = 4'h1;
		end else if (gap == 4'hf) begin
			next_gap = gap;
		end else begin
			next_gap = gap + 4'h1;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gap <= 4'h0;
		end else begin
			gap <= next_gap;
		end
	end

	assign pif.pump_clk = pump_q;
	assign pif.divide   = div_req;

	a_pump_ratio_floor: assert property (@(posedge clock) disable iff (!arst_n)
		pump_q |-> gap >= P1OVR_PUMP_MIN_DIV_W) else $error("pump pulses closer than the ceiling allows");
	a_pump_no_double: assert property (@(posedge clock) disable iff (!arst_n)
		pump_q |=> !pump_q) else $error("pump pulses back to back");
endmodule

// *** core/p1ovr_top.sv ***
// Port 1 signal override multiplexer and regulated output setup registers, APB slave
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module p1ovr_top
	import p1ovr_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Override sources from inside the chip
	input  wire logic        timer_output,
	input  wire logic        clock_32k,
	input  wire logic        relaxation_osc_out,
	input  wire logic        comparator_one_out,
	input  wire logic        comparator_zero_out,
	input  wire logic        sleep_tick_irq,
	input  wire logic        system_clock,
	input  wire logic        cap_sense_out,
	input  wire logic        cap_sense_clk,
	input  wire logic        prng_config_bit7,
	input  wire logic        sleep_mode,
	// Normal port 1 sources and pin result
	input  wire logic [7:0]  port1_normal_out,
	output logic      [7:0]  port1_pin_out,
	output logic      [7:0]  port1_override_active,
	// Port 0 pin 4 alternative route
	input  wire logic        port0_pin4_route_en,
	input  wire logic        port0_pin4_route_sel,
	output logic             port0_pin4_alt_out,
	// Regulator controls
	output logic      [2:0]  reg_level,
	output logic             pump_clk
);
	// Synchronised copies of outside signals
	logic [10:0] sync1;
	logic [10:0] sync2;
	logic [10:0] raw_in;

	logic [7:0] alt_sel;
	logic [7:0] next_alt_sel;
	logic [7:0] reg_setup;
	logic [7:0] next_reg_setup;
	logic [31:0] next_prdata;
	logic        next_pready;
	logic        next_pslverr;
	logic [7:0]  next_pin_out;
	logic [7:0]  next_active;
	logic        next_p0_alt;
	logic        pump_q;

	p1ovr_pump_if pif ();

	// Two flops on every asynchronous source; glitches on clocks are sampled, not passed
	assign raw_in = {sleep_mode, prng_config_bit7, cap_sense_clk, cap_sense_out, system_clock,
		sleep_tick_irq, comparator_zero_out, comparator_one_out, relaxation_osc_out,
		clock_32k, timer_output};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1 <= 11'h000;
			sync2 <= 11'h000;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	logic s_timer, s_c32k, s_ro, s_comparator_one_out, s_comparator_zero_out, s_slp, s_sys, s_cso, s_csc, s_prng7, s_sleep;
	assign {s_sleep, s_prng7, s_csc, s_cso, s_sys, s_slp, s_comparator_zero_out, s_comparator_one_out, s_ro, s_c32k, s_timer} = sync2;

	function automatic logic pick(input logic sel, input logic src0, input logic src1);
		pick = sel ? src1 : src0;
	endfunction

	function automatic logic is_setup(input logic [31:0] addr);
		is_setup = (addr[9:0] == P1OVR_ADDR_REG_SETUP) && (addr[31:10] == 22'h0);
	endfunction

	function automatic logic is_alt(input logic [31:0] addr);
		is_alt = (addr[9:0] == P1OVR_ADDR_ALT_SEL) && (addr[31:10] == 22'h0);
	endfunction

	// APB register access: single-cycle wait-free answer in the access phase
	always_comb begin
		next_alt_sel   = alt_sel;
		next_reg_setup = reg_setup;
		next_prdata    = 32'h0;
		next_pready    = 1'b0;
		next_pslverr   = 1'b0;
		if (psel && !penable) begin
			next_pready = 1'b1;
			if (is_alt(paddr)) begin
				if (pwrite) begin
					next_alt_sel = pwdata[7:0];
				end else begin
					next_prdata = {24'h0, alt_sel};
				end
			end else if (is_setup(paddr)) begin
				if (pwrite) begin
					// Reserved bits are kept at zero whatever firmware writes
					next_reg_setup = pwdata[7:0] & P1OVR_REG_SETUP_MASK;
				end else begin
					next_prdata = {24'h0, reg_setup};
				end
			end else begin
				next_pslverr = 1'b1;
			end
		end
	end

	// Writes take effect at the setup edge, the same edge at which pready rises
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			alt_sel   <= P1OVR_ALT_SEL_RESET;
			reg_setup <= P1OVR_REG_SETUP_RESET;
			prdata    <= 32'h0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
		end else begin
			alt_sel   <= next_alt_sel;
			reg_setup <= next_reg_setup;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
		end
	end

	// Pin multiplexer: odd pins pass through, even pins may be overridden
	always_comb begin
		logic src6, src4, src2, src0, cs_src;
		src6 = 1'b0;
		src4 = 1'b0;
		src2 = 1'b0;
		src0 = 1'b0;
		cs_src = 1'b0;
		next_pin_out = port1_normal_out;
		next_active  = 8'h00;
		src6 = pick(alt_sel[P1OVR_PIN6_SEL], s_timer, s_c32k);
		src4 = pick(alt_sel[P1OVR_PIN4_SEL], s_ro, s_comparator_one_out);
		cs_src = pick(s_prng7, s_cso, s_csc);
		src2 = pick(alt_sel[P1OVR_PIN2_SEL], s_sys, cs_src);
		src0 = pick(alt_sel[P1OVR_PIN0_SEL], s_slp, s_comparator_zero_out);
		// Override wins over every other function on the pin
		if (alt_sel[P1OVR_PIN6_EN]) begin
			next_pin_out[6] = src6;
			next_active[6]  = 1'b1;
		end
		if (alt_sel[P1OVR_PIN4_EN]) begin
			next_pin_out[4] = src4;
			next_active[4]  = 1'b1;
		end
		if (alt_sel[P1OVR_PIN2_EN]) begin
			next_pin_out[2] = src2;
			next_active[2]  = 1'b1;
		end
		if (alt_sel[P1OVR_PIN0_EN]) begin
			next_pin_out[0] = src0;
			next_active[0]  = 1'b1;
		end
		// Port 0 route is gated off during sleep; the pin 6 route above is not
		next_p0_alt = port0_pin4_route_en && !s_sleep && pick(port0_pin4_route_sel, s_timer, s_c32k);
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			port1_pin_out         <= 8'h00;
			port1_override_active <= 8'h00;
			port0_pin4_alt_out    <= 1'b0;
			reg_level             <= 3'h0;
			pump_clk              <= 1'b0;
		end else begin
			port1_pin_out         <= next_pin_out;
			port1_override_active <= next_active;
			port0_pin4_alt_out    <= next_p0_alt;
			reg_level             <= reg_setup[P1OVR_LEVEL_MSB:P1OVR_LEVEL_LSB];
			pump_clk              <= pump_q;
		end
	end

	assign pif.clk_sel = reg_setup[P1OVR_CLKSEL_MSB:P1OVR_CLKSEL_LSB];
	assign pump_q      = pif.pump_clk;

	p1ovr_pump_clk u_pump (
		.clock  (clock),
		.arst_n (arst_n),
		.pif    (pif)
	);

	// Register bus answers
	a_ready_after_setup: assert property (@(posedge clock) disable iff (!arst_n)
		psel && !penable
		|=> pready)
		else $error("no answer after setup cycle");
	a_ready_needs_setup: assert property (@(posedge clock) disable iff (!arst_n)
		pready
		|-> $past(psel && !penable))
		else $error("answer without setup cycle");
	a_ready_one_cycle: assert property (@(posedge clock) disable iff (!arst_n)
		pready
		|=> !pready)
		else $error("answer stands too long");
	a_error_with_ready: assert property (@(posedge clock) disable iff (!arst_n)
		pslverr
		|-> pready)
		else $error("error flag without answer");
	a_error_unmapped: assert property (@(posedge clock) disable iff (!arst_n)
		pready && $past(psel && !penable && !is_alt(paddr) && !is_setup(paddr))
		|-> pslverr)
		else $error("unmapped access not refused");
	a_idle_prdata_zero: assert property (@(posedge clock) disable iff (!arst_n)
		!pready
		|-> prdata == 32'h0)
		else $error("read data outside answer");
	a_read_alt_data: assert property (@(posedge clock) disable iff (!arst_n)
		pready && $past(psel && !penable && !pwrite && is_alt(paddr))
		|-> prdata == {24'h0, $past(alt_sel)})
		else $error("override select read wrong");
	a_read_setup_data: assert property (@(posedge clock) disable iff (!arst_n)
		pready && $past(psel && !penable && !pwrite && is_setup(paddr))
		|-> prdata == {24'h0, $past(reg_setup)})
		else $error("regulator setup read wrong");
	a_write_alt_lands: assert property (@(posedge clock) disable iff (!arst_n)
		psel && !penable && pwrite && is_alt(paddr)
		|=> alt_sel == $past(pwdata[7:0]))
		else $error("override select write lost");
	a_write_setup_lands: assert property (@(posedge clock) disable iff (!arst_n)
		psel && !penable && pwrite && is_setup(paddr)
		|=> reg_setup == ($past(pwdata[7:0]) & P1OVR_REG_SETUP_MASK))
		else $error("regulator setup write lost");
	a_unmapped_write_kept: assert property (@(posedge clock) disable iff (!arst_n)
		psel && !penable && pwrite && !is_alt(paddr) && !is_setup(paddr)
		|=> $stable(alt_sel) && $stable(reg_setup))
		else $error("unmapped write changed a register");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!arst_n)
		reg_setup != 8'h00
		|-> (reg_setup & ~P1OVR_REG_SETUP_MASK) == 8'h00)
		else $error("reserved regulator bits set");

	// Pin multiplexer
	a_pin6_override: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN6_EN] && alt_sel[P1OVR_PIN6_SEL]
		|=> port1_pin_out[6] == $past(s_c32k) && port1_override_active[6])
		else $error("pin 6 override not applied");
	a_pin6_source: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN6_EN] && !alt_sel[P1OVR_PIN6_SEL]
		|=> port1_pin_out[6] == $past(s_timer))
		else $error("pin 6 source wrong");
	a_pin6_disabled: assert property (@(posedge clock) disable iff (!arst_n)
		!alt_sel[P1OVR_PIN6_EN]
		|=> !port1_override_active[6] && port1_pin_out[6] == $past(port1_normal_out[6]))
		else $error("pin 6 override leaks");
	a_pin4_source: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN4_EN] && alt_sel[P1OVR_PIN4_SEL]
		|=> port1_pin_out[4] == $past(s_comparator_one_out) && port1_override_active[4])
		else $error("pin 4 source wrong");
	a_pin4_relax: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN4_EN] && !alt_sel[P1OVR_PIN4_SEL]
		|=> port1_pin_out[4] == $past(s_ro))
		else $error("pin 4 oscillator source wrong");
	a_pin4_disabled: assert property (@(posedge clock) disable iff (!arst_n)
		!alt_sel[P1OVR_PIN4_EN]
		|=> !port1_override_active[4] && port1_pin_out[4] == $past(port1_normal_out[4]))
		else $error("pin 4 override leaks");
	a_pin2_capsense: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN2_EN] && alt_sel[P1OVR_PIN2_SEL] && s_prng7
		|=> port1_pin_out[2] == $past(s_csc))
		else $error("pin 2 cap sense clock wrong");
	a_pin2_capout: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN2_EN] && alt_sel[P1OVR_PIN2_SEL] && !s_prng7
		|=> port1_pin_out[2] == $past(s_cso))
		else $error("pin 2 cap sense output wrong");
	a_pin2_system_clock: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN2_EN] && !alt_sel[P1OVR_PIN2_SEL]
		|=> port1_pin_out[2] == $past(s_sys) && port1_override_active[2])
		else $error("pin 2 system clock wrong");
	a_pin2_disabled: assert property (@(posedge clock) disable iff (!arst_n)
		!alt_sel[P1OVR_PIN2_EN]
		|=> !port1_override_active[2] && port1_pin_out[2] == $past(port1_normal_out[2]))
		else $error("pin 2 override leaks");
	a_pin0_source: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN0_EN] && !alt_sel[P1OVR_PIN0_SEL]
		|=> port1_pin_out[0] == $past(s_slp))
		else $error("pin 0 sleep tick wrong");
	a_pin0_comparator: assert property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN0_EN] && alt_sel[P1OVR_PIN0_SEL]
		|=> port1_pin_out[0] == $past(s_comparator_zero_out) && port1_override_active[0])
		else $error("pin 0 comparator source wrong");
	a_pin0_disabled: assert property (@(posedge clock) disable iff (!arst_n)
		!alt_sel[P1OVR_PIN0_EN]
		|=> !port1_override_active[0] && port1_pin_out[0] == $past(port1_normal_out[0]))
		else $error("pin 0 override leaks");
	a_odd_pins_pass: assert property (@(posedge clock) disable iff (!arst_n)
		1'b1
		|=> {port1_pin_out[7], port1_pin_out[5], port1_pin_out[3], port1_pin_out[1]}
			== $past({port1_normal_out[7], port1_normal_out[5], port1_normal_out[3], port1_normal_out[1]}))
		else $error("odd pin disturbed");

	// Port 0 route and regulator
	a_port0_sleep_block: assert property (@(posedge clock) disable iff (!arst_n)
		s_sleep
		|=> !port0_pin4_alt_out)
		else $error("port 0 route open in sleep");
	a_port0_route_awake: assert property (@(posedge clock) disable iff (!arst_n)
		port0_pin4_route_en && !port0_pin4_route_sel && !s_sleep
		|=> port0_pin4_alt_out == $past(s_timer))
		else $error("port 0 route not passed while awake");
	a_level_follows: assert property (@(posedge clock) disable iff (!arst_n)
		psel && !penable && pwrite && is_setup(paddr) ##1 1'b1
		|=> reg_level == $past(pwdata[5:3], 2))
		else $error("regulator level not applied");
	a_pump_divide: assert property (@(posedge clock) disable iff (!arst_n)
		pif.clk_sel == P1OVR_CLKSEL_DIV2
		|-> pif.divide >= P1OVR_PUMP_MIN_DIV_W)
		else $error("pump ratio below ceiling");

	c_pin6_clock_32k: cover property (@(posedge clock) disable iff (!arst_n)
		alt_sel[P1OVR_PIN6_EN] && alt_sel[P1OVR_PIN6_SEL]);
	c_all_enabled: cover property (@(posedge clock) disable iff (!arst_n) alt_sel == 8'h55);
	c_bad_addr: cover property (@(posedge clock) disable iff (!arst_n) pslverr);
	c_sleep_block: cover property (@(posedge clock) disable iff (!arst_n) s_sleep && port0_pin4_route_en);
	c_route_open: cover property (@(posedge clock) disable iff (!arst_n) port0_pin4_alt_out);
endmodule

// *** shared/p1ovr_pkg.sv ***
// Package holding register map, field positions and constants of the port 1 override block
package p1ovr_pkg;
	// Register word offsets (printed offsets 0xdd and 0xde are not multiples of four, so they are indices)
	localparam logic [7:0]  P1OVR_IDX_ALT_SEL   = 8'hdd;
	localparam logic [7:0]  P1OVR_IDX_REG_SETUP = 8'hde;
	localparam logic [9:0]  P1OVR_ADDR_ALT_SEL   = {P1OVR_IDX_ALT_SEL, 2'b00};
	localparam logic [9:0]  P1OVR_ADDR_REG_SETUP = {P1OVR_IDX_REG_SETUP, 2'b00};
	// Reset values
	localparam logic [7:0]  P1OVR_ALT_SEL_RESET   = 8'h00;
	localparam logic [7:0]  P1OVR_REG_SETUP_RESET = 8'h00;
	// Field positions in the alternate output select register
	localparam int P1OVR_PIN0_EN  = 0;
	localparam int P1OVR_PIN0_SEL = 1;
	localparam int P1OVR_PIN2_EN  = 2;
	localparam int P1OVR_PIN2_SEL = 3;
	localparam int P1OVR_PIN4_EN  = 4;
	localparam int P1OVR_PIN4_SEL = 5;
	localparam int P1OVR_PIN6_EN  = 6;
	localparam int P1OVR_PIN6_SEL = 7;
	// Regulator setup fields
	localparam int P1OVR_LEVEL_LSB = 3;
	localparam int P1OVR_LEVEL_MSB = 5;
	localparam int P1OVR_CLKSEL_LSB = 0;
	localparam int P1OVR_CLKSEL_MSB = 1;
	localparam logic [7:0] P1OVR_REG_SETUP_MASK = 8'h3b;
	// Pump clock selection codes
	localparam logic [1:0] P1OVR_CLKSEL_DIV2 = 2'h2;
	localparam logic [1:0] P1OVR_CLKSEL_DIV1 = 2'h1;
	// Timing: pump clock ceiling and system clock rate
	localparam int P1OVR_PUMP_MAX_KHZ = 12000;
	localparam int P1OVR_CLK_KHZ      = 40000;
	// Divide ratio at least clock/ceiling, rounded up so the pump never exceeds its ceiling
	localparam int P1OVR_PUMP_MIN_DIV = (P1OVR_CLK_KHZ + P1OVR_PUMP_MAX_KHZ - 1) / P1OVR_PUMP_MAX_KHZ;
	localparam logic [3:0] P1OVR_PUMP_MIN_DIV_W = P1OVR_PUMP_MIN_DIV[3:0];
endpackage

// *** shared/p1ovr_pump_if.sv ***
// Interface between register logic and the charge pump clock generator
`timescale 1ns/1ps
interface p1ovr_pump_if;
	logic [1:0] clk_sel;
	logic       pump_clk;
	logic [3:0] divide;
	modport ctrl (output clk_sel, input pump_clk, input divide);
	modport pump (input clk_sel, output pump_clk, output divide);
endinterface

// *** tb/port1_signal_override_tb.sv ***
// Self-checking bench for the port 1 override block
`timescale 1ns/1ps
module port1_signal_override_tb
	import p1ovr_pkg::*;
;
	logic        clock;
	logic        arst_n;
	logic        psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata;
	logic        pready, pslverr;
	logic [10:0] src;
	logic [7:0]  nrm, pin_out, act;
	logic        ren, rsel, alt_out, pump_clk, chk_pin;
	logic [2:0]  lvl;
	logic [32:0] rd_q[$];
	logic [19:0] pin_q[$];
	int          failures, check_count;

	p1ovr_top dut (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_output(src[0]), .clock_32k(src[1]), .relaxation_osc_out(src[2]),
		.comparator_one_out(src[3]), .comparator_zero_out(src[4]), .sleep_tick_irq(src[5]),
		.system_clock(src[6]), .cap_sense_out(src[7]), .cap_sense_clk(src[8]),
		.prng_config_bit7(src[9]), .sleep_mode(src[10]), .port1_normal_out(nrm),
		.port1_pin_out(pin_out), .port1_override_active(act), .port0_pin4_route_en(ren),
		.port0_pin4_route_sel(rsel), .port0_pin4_alt_out(alt_out), .reg_level(lvl), .pump_clk(pump_clk));

	always #12.5 clock = ~clock;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Waits for the answer without assuming its latency
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		@(posedge clock);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clock);
			n++;
		end
		if (n >= 50) failures++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic err);
		rd_q.push_back({err, d});
		apb(1'b0, a, 32'h0);
	endtask

	task automatic pump_period(input logic [1:0] c);
		int n;
		int k;
		apb(1'b1, P1OVR_ADDR_REG_SETUP, {30'h0, c});
		repeat (20) @(posedge clock);
		n = 0;
		while (pump_clk !== 1'b1 && n < 50) begin
			@(posedge clock);
			n++;
		end
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pump_clk !== 1'b1 && k < 50);
		chk(k, (c == 2'h2) ? 8 : 4, "pump period");
	endtask

	// Monitor: results are matched against the oldest note
	always @(posedge clock) begin
		logic [32:0] e;
		logic [19:0] p;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = rd_q.pop_front();
			chk({31'h0, pslverr}, {31'h0, e[32]}, "read error flag");
			chk(prdata, e[31:0], "read data");
		end
		if (chk_pin) begin
			p = pin_q.pop_front();
			chk({12'h0, lvl, alt_out, act, pin_out}, {12'h0, p}, "pin state");
		end
	end

	initial begin
		logic [7:0] a;
		logic [7:0] cfg;
		logic [7:0] p;
		logic       o;
		clock = 0; arst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		src = 0; nrm = 0; ren = 0; rsel = 0; chk_pin = 0; failures = 0; check_count = 0;
		repeat (4) @(posedge clock);
		arst_n <= 1'b1;
		void'($urandom(27));
		rd(P1OVR_ADDR_ALT_SEL, 32'h0, 1'b0);
		rd(P1OVR_ADDR_REG_SETUP, 32'h0, 1'b0);
		// Unmapped place: refused, write has no effect
		apb(1'b1, 32'h0000_0380, 32'hffff_ffff);
		rd(32'h0000_0380, 32'h0, 1'b1);
		rd(P1OVR_ADDR_ALT_SEL, 32'h0, 1'b0);
		// Pin drive modes sit outside this block and are taken as output modes
		for (int i = 0; i < 48; i++) begin
			a = 8'($urandom);
			// Firmware keeps reserved bits zero and uses only the two listed clock codes
			cfg = {2'b00, 3'($urandom), 1'b0, ($urandom % 2 == 0) ? P1OVR_CLKSEL_DIV1 : P1OVR_CLKSEL_DIV2};
			src <= 11'($urandom);
			nrm <= 8'($urandom);
			ren <= 1'($urandom);
			rsel <= 1'($urandom);
			apb(1'b1, P1OVR_ADDR_ALT_SEL, {24'($urandom), a});
			apb(1'b1, P1OVR_ADDR_REG_SETUP, {24'h0, cfg});
			repeat (5) @(posedge clock);
			p = nrm;
			if (a[6]) p[6] = a[7] ? src[1] : src[0];
			if (a[4]) p[4] = a[5] ? src[3] : src[2];
			if (a[2]) p[2] = a[3] ? (src[9] ? src[8] : src[7]) : src[6];
			if (a[0]) p[0] = a[1] ? src[4] : src[5];
			o = ren && !src[10] && (rsel ? src[1] : src[0]);
			pin_q.push_back({cfg[5:3], o, a & 8'h55, p});
			chk_pin <= 1'b1;
			@(posedge clock);
			chk_pin <= 1'b0;
			rd(P1OVR_ADDR_ALT_SEL, {24'h0, a}, 1'b0);
			rd(P1OVR_ADDR_REG_SETUP, {24'h0, cfg & 8'h3b}, 1'b0);
		end
		pump_period(P1OVR_CLKSEL_DIV1);
		pump_period(P1OVR_CLKSEL_DIV2);
		pump_period(P1OVR_CLKSEL_DIV1);
		repeat (3) @(posedge clock);
		print_verdict();
	end

	initial begin
		#(25 * 20000);
		failures++;
		print_verdict();
	end
endmodule
